// [design/pd_info_pkg.sv]
// shared types and constants for the informational exchange engine
package pd_info_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLOCK_MHZ          = 100;
	localparam int REPLY_WAIT_US      = 27;
	localparam int REPLY_WAIT_CYCLES  = REPLY_WAIT_US * CLOCK_MHZ;
	localparam int REPLY_WAIT_W       = 16;

	// ------------------------------------------------------------
	// message kinds seen by the protocol layer
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		msg_none,
		msg_get_battery_caps,
		msg_battery_caps,
		msg_get_cell_status,
		msg_cell_status,
		msg_get_maker_info,
		msg_maker_info,
		msg_sec_query,
		msg_sec_answer
	} msg_kind_t;

	localparam int PAYLOAD_W = 32;

	// message with payload, both directions
	typedef struct packed {
		msg_kind_t              kind;
		logic [PAYLOAD_W-1:0]   payload;
	} msg_t;

	// which ready state the port sits in
	typedef enum logic [1:0] {
		role_source,
		role_sink,
		role_cable
	} idle_role_t;

	// outcome reported to the policy manager
	typedef enum logic [2:0] {
		out_none,
		out_status_ok,
		out_status_timeout,
		out_maker_ok,
		out_maker_timeout,
		out_sec_answer
	} outcome_kind_t;

	typedef struct packed {
		outcome_kind_t          kind;
		logic [PAYLOAD_W-1:0]   payload;
	} outcome_t;

endpackage

// [design/reply_wait_timer.sv]
// one-shot sender response timer
`timescale 1ns/1ps
`default_nettype none
module reply_wait_timer #(
	parameter int CYCLES = pd_info_pkg::REPLY_WAIT_CYCLES
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_b,
	// control
	input  wire logic start,
	input  wire logic stop,
	// status
	output logic      expired
);
	initial begin
		if (CYCLES < 2 || CYCLES >= (1 << pd_info_pkg::REPLY_WAIT_W)) begin
			$error("reply_wait_timer: CYCLES out of range");
		end
	end

	localparam logic [pd_info_pkg::REPLY_WAIT_W-1:0] LOAD =
		pd_info_pkg::REPLY_WAIT_W'(CYCLES - 1);

	logic [pd_info_pkg::REPLY_WAIT_W-1:0] count;
	logic                                 running;
	logic [pd_info_pkg::REPLY_WAIT_W-1:0] next_count;
	logic                                 next_running;
	logic                                 next_expired;

	always_comb begin
		next_count   = count;
		next_running = running;
		next_expired = 1'b0;
		if (start) begin
			next_count   = LOAD;
			next_running = 1'b1;
		end else if (stop) begin
			next_running = 1'b0;
		end else if (running) begin
			if (count == '0) begin
				next_running = 1'b0;
				next_expired = 1'b1;
			end else begin
				next_count = count - 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			count   <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end else begin
			count   <= next_count;
			running <= next_running;
			expired <= next_expired;
		end
	end
endmodule
`default_nettype wire

// [design/pd_info_query_policy_fsm.sv]
// informational exchange engine of a port policy state machine
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module pd_info_query_policy_fsm #(
	parameter int REPLY_WAIT_CYCLES = pd_info_pkg::REPLY_WAIT_CYCLES
) (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	// port role
	input  wire logic                  dual_role_port,
	input  wire pd_info_pkg::idle_role_t role,
	input  wire logic                  hard_reset,
	input  wire logic                  swap_request,
	// manager requests
	input  wire logic                  req_cell_status,
	input  wire logic                  req_maker_info,
	input  wire logic                  req_sec_query,
	input  wire logic [31:0]           req_arg,
	// manager data replies
	input  wire logic                  mgr_data_valid,
	input  wire logic [31:0]           mgr_data,
	// manager fetch and report
	output logic                       mgr_fetch,
	output pd_info_pkg::msg_kind_t     mgr_fetch_kind,
	output logic [31:0]                mgr_fetch_arg,
	output logic                       report_valid,
	output pd_info_pkg::outcome_t      report,
	output logic                       busy,
	output logic                       swap_start,
	output logic                       to_default,
	// protocol layer
	input  wire logic                  rx_valid,
	input  wire pd_info_pkg::msg_t     rx_msg,
	input  wire logic                  tx_done,
	output logic                       tx_valid,
	output pd_info_pkg::msg_t          tx_msg
);
	typedef enum logic [3:0] {
		idle_state,
		serve_battery_caps_state,
		request_cell_status_state,
		serve_cell_status_state,
		request_maker_info_state,
		serve_maker_info_state,
		send_sec_query_state,
		send_sec_answer_state,
		sec_answer_rx_state
	} state_t;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	state_t                 state, next_state;
	logic                   waiting_tx, next_waiting_tx;
	logic                   next_mgr_fetch, next_tx_valid, next_report_valid;
	pd_info_pkg::msg_kind_t next_mgr_fetch_kind;
	logic [31:0]            next_mgr_fetch_arg, wait_age, next_wait_age;
	pd_info_pkg::msg_t      next_tx_msg;
	pd_info_pkg::outcome_t  next_report;
	logic                   next_swap_start, next_to_default;
	logic                   timer_start, timer_stop, timer_expired;

	reply_wait_timer #(
		.CYCLES (REPLY_WAIT_CYCLES)
	) u_timer (
		.clock   (clock),
		.rst_b   (rst_b),
		.start   (timer_start),
		.stop    (timer_stop),
		.expired (timer_expired)
	);

	function automatic logic rx_is(input pd_info_pkg::msg_kind_t k);
		return rx_valid && rx_msg.kind == k;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic src_snk;
		src_snk             = role != pd_info_pkg::role_cable;
		next_state          = state;
		next_waiting_tx     = waiting_tx;
		next_mgr_fetch      = 1'b0;
		next_mgr_fetch_kind = mgr_fetch_kind;
		next_mgr_fetch_arg  = mgr_fetch_arg;
		next_tx_valid       = 1'b0;
		next_tx_msg         = tx_msg;
		next_report_valid   = 1'b0;
		next_report         = report;
		next_swap_start     = 1'b0;
		next_to_default     = 1'b0;
		timer_start         = 1'b0;
		timer_stop          = 1'b0;
		unique case (state)
			idle_state: begin
				// one engine serves all three idle roles
				if (src_snk && rx_is(pd_info_pkg::msg_get_battery_caps)) begin
					next_state          = serve_battery_caps_state;
					next_mgr_fetch      = 1'b1;
					next_mgr_fetch_kind = pd_info_pkg::msg_battery_caps;
					next_mgr_fetch_arg  = rx_msg.payload;
					next_waiting_tx     = 1'b0;
				end else if (src_snk && rx_is(pd_info_pkg::msg_get_cell_status)) begin
					next_state          = serve_cell_status_state;
					next_mgr_fetch      = 1'b1;
					next_mgr_fetch_kind = pd_info_pkg::msg_cell_status;
					next_mgr_fetch_arg  = rx_msg.payload;
					next_waiting_tx     = 1'b0;
				end else if (rx_is(pd_info_pkg::msg_get_maker_info)) begin
					next_state          = serve_maker_info_state;
					next_mgr_fetch      = 1'b1;
					next_mgr_fetch_kind = pd_info_pkg::msg_maker_info;
					next_mgr_fetch_arg  = rx_msg.payload;
					next_waiting_tx     = 1'b0;
				end else if (rx_is(pd_info_pkg::msg_sec_query)) begin
					next_state          = send_sec_answer_state;
					next_mgr_fetch      = 1'b1;
					next_mgr_fetch_kind = pd_info_pkg::msg_sec_answer;
					next_mgr_fetch_arg  = rx_msg.payload;
					next_waiting_tx     = 1'b0;
				end else if (src_snk && rx_is(pd_info_pkg::msg_sec_answer)) begin
					next_state          = sec_answer_rx_state;
					next_report_valid   = 1'b1;
					next_report         = '{pd_info_pkg::out_sec_answer, rx_msg.payload};
				end else if (src_snk && req_cell_status) begin
					next_state    = request_cell_status_state;
					next_tx_valid = 1'b1;
					next_tx_msg   = '{pd_info_pkg::msg_get_cell_status, req_arg};
					timer_start   = 1'b1;
				end else if (src_snk && req_maker_info) begin
					next_state    = request_maker_info_state;
					next_tx_valid = 1'b1;
					next_tx_msg   = '{pd_info_pkg::msg_get_maker_info, req_arg};
					timer_start   = 1'b1;
				end else if (src_snk && req_sec_query) begin
					next_state    = send_sec_query_state;
					next_tx_valid = 1'b1;
					next_tx_msg   = '{pd_info_pkg::msg_sec_query, req_arg};
				end else if (dual_role_port && src_snk && swap_request) begin
					// swap handed to the swap machine
					next_swap_start = 1'b1;
				end
			end
			serve_battery_caps_state, serve_cell_status_state,
			serve_maker_info_state, send_sec_answer_state: begin
				if (!waiting_tx && mgr_data_valid) begin
					// caps reply kind chosen at fetch time
					next_tx_valid   = 1'b1;
					next_tx_msg     = '{mgr_fetch_kind, mgr_data};
					next_waiting_tx = 1'b1;
				end else if (waiting_tx && tx_done) begin
					next_state      = idle_state;
					next_waiting_tx = 1'b0;
				end
			end
			request_cell_status_state: begin
				if (rx_is(pd_info_pkg::msg_cell_status)) begin
					next_state        = idle_state;
					timer_stop        = 1'b1;
					next_report_valid = 1'b1;
					next_report       = '{pd_info_pkg::out_status_ok, rx_msg.payload};
				end else if (timer_expired) begin
					next_state        = idle_state;
					next_report_valid = 1'b1;
					next_report       = '{pd_info_pkg::out_status_timeout, 32'h0000_0000};
				end
			end
			request_maker_info_state: begin
				if (rx_is(pd_info_pkg::msg_maker_info)) begin
					next_state        = idle_state;
					timer_stop        = 1'b1;
					next_report_valid = 1'b1;
					next_report       = '{pd_info_pkg::out_maker_ok, rx_msg.payload};
				end else if (timer_expired) begin
					next_state        = idle_state;
					next_report_valid = 1'b1;
					next_report       = '{pd_info_pkg::out_maker_timeout, 32'h0000_0000};
				end
			end
			send_sec_query_state: begin
				// no wait for an answer here
				if (tx_done) begin
					next_state = idle_state;
				end
			end
			sec_answer_rx_state: begin
				// manager informed by the one-cycle report
				next_state = idle_state;
			end
			default: begin
				next_state = idle_state;
			end
		endcase
		if (hard_reset) begin
			next_state        = idle_state;
			next_waiting_tx   = 1'b0;
			next_mgr_fetch    = 1'b0;
			next_tx_valid     = 1'b0;
			next_report_valid = 1'b0;
			next_swap_start   = 1'b0;
			next_to_default   = dual_role_port;
			timer_stop        = 1'b1;
			timer_start       = 1'b0;
		end
		// age of a status request, so the timeout check needs no long delay range
		next_wait_age = (state == request_cell_status_state && next_state == state) ? wait_age + 32'h1 : 32'h0;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state          <= idle_state;
			waiting_tx     <= 1'b0;
			mgr_fetch      <= 1'b0;
			mgr_fetch_kind <= pd_info_pkg::msg_none;
			mgr_fetch_arg  <= 32'h0000_0000;
			tx_valid       <= 1'b0;
			tx_msg         <= '0;
			report_valid   <= 1'b0;
			report         <= '0;
			busy           <= 1'b0;
			swap_start     <= 1'b0;
			to_default     <= 1'b0;
			wait_age       <= 32'h0000_0000;
		end else begin
			state          <= next_state;
			waiting_tx     <= next_waiting_tx;
			mgr_fetch      <= next_mgr_fetch;
			mgr_fetch_kind <= next_mgr_fetch_kind;
			mgr_fetch_arg  <= next_mgr_fetch_arg;
			tx_valid       <= next_tx_valid;
			tx_msg         <= next_tx_msg;
			report_valid   <= next_report_valid;
			report         <= next_report;
			busy           <= next_state != idle_state;
			swap_start     <= next_swap_start;
			to_default     <= next_to_default;
			wait_age       <= next_wait_age;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b || hard_reset);

	sequence s_status_req;
		state == idle_state && role != pd_info_pkg::role_cable && !rx_valid && req_cell_status;
	endsequence

	a_status_request_sent: assert property (s_status_req |=> tx_valid && tx_msg.kind == pd_info_pkg::msg_get_cell_status) else $error("status request not sent");
	a_caps_reply_kind: assert property (tx_valid && state == serve_battery_caps_state |-> tx_msg.kind == pd_info_pkg::msg_battery_caps) else $error("caps reply kind wrong");
	a_caps_fetch: assert property (state == idle_state && role != pd_info_pkg::role_cable && rx_valid && rx_msg.kind == pd_info_pkg::msg_get_battery_caps |=> mgr_fetch && state == serve_battery_caps_state) else $error("caps fetch missing");
	a_serve_return: assert property (state == serve_cell_status_state && waiting_tx && tx_done |=> state == idle_state) else $error("serve state did not return");
	a_status_reply_report: assert property (state == request_cell_status_state && rx_valid && rx_msg.kind == pd_info_pkg::msg_cell_status |=> report_valid && report.kind == pd_info_pkg::out_status_ok) else $error("status reply not reported");
	a_status_timeout: assert property (state == request_cell_status_state |-> wait_age <= REPLY_WAIT_CYCLES) else $error("status request never ended");
	a_maker_serve_cable: assert property (state == idle_state && rx_valid && rx_msg.kind == pd_info_pkg::msg_get_maker_info |=> state == serve_maker_info_state) else $error("maker serve not entered");
	a_query_returns: assert property (state == send_sec_query_state && tx_done |=> state == idle_state) else $error("query state stuck");
	a_answer_rx_once: assert property (state == sec_answer_rx_state |=> state == idle_state && $past(report_valid)) else $error("answer not passed on");
endmodule
`default_nettype wire

// [tb/pd_partner_model.sv]
// far port partner and its protocol layer, seen from the engine
`timescale 1ns/1ps
`default_nettype none
module pd_partner_model (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst_b,
	// engine side
	input  wire logic              tx_valid,
	input  wire pd_info_pkg::msg_t tx_msg,
	output logic                   tx_done,
	output logic                   rx_valid,
	output pd_info_pkg::msg_t      rx_msg,
	// bench control
	input  wire logic              answer,
	input  wire logic              inj_valid,
	input  wire pd_info_pkg::msg_t inj_msg
);
	int                done_cnt;
	int                rep_cnt;
	pd_info_pkg::msg_t rep;
	logic [35:0]       junk;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			done_cnt <= 0;
			rep_cnt  <= 0;
			tx_done  <= 1'b0;
			rep      <= '0;
			junk     <= 36'h5;
		end else begin
			tx_done <= (done_cnt == 1);
			// idle bus never repeats the last message
			junk <= junk + 36'h3;
			if (done_cnt > 0)
				done_cnt <= done_cnt - 1;
			if (rep_cnt > 0)
				rep_cnt <= rep_cnt - 1;
			if (tx_valid) begin
				// delay taken from the payload so it varies yet repeats
				done_cnt <= 1 + int'(tx_msg.payload[1:0]);
				if (answer && (tx_msg.kind == pd_info_pkg::msg_get_cell_status ||
						tx_msg.kind == pd_info_pkg::msg_get_maker_info)) begin
					rep.kind <= (tx_msg.kind == pd_info_pkg::msg_get_cell_status) ?
						pd_info_pkg::msg_cell_status : pd_info_pkg::msg_maker_info;
					rep.payload <= ~tx_msg.payload;
					rep_cnt <= 3 + int'(tx_msg.payload[1:0]);
				end
			end
		end
	end

	assign rx_valid = inj_valid | (rep_cnt == 1);
	assign rx_msg   = inj_valid ? inj_msg : (rep_cnt == 1) ? rep : pd_info_pkg::msg_t'(junk);
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench of the informational exchange engine
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam int WAIT = 16;
	logic clock, rst_b, dual_role_port, hard_reset, swap_request, answer, inj_valid;
	logic req_cell_status, req_maker_info, req_sec_query, mgr_data_valid, h;
	logic mgr_fetch, report_valid, busy, swap_start, to_default, rx_valid, tx_done, tx_valid;
	logic [31:0] req_arg, mgr_data, mgr_fetch_arg;
	pd_info_pkg::idle_role_t role;
	pd_info_pkg::msg_kind_t  mgr_fetch_kind;
	pd_info_pkg::outcome_t   report;
	pd_info_pkg::msg_t       rx_msg, tx_msg, inj_msg;
	pd_info_pkg::msg_kind_t  kinds [5];
	int                      n_fail, compares, seed, mcnt, n;

	pd_info_query_policy_fsm #(.REPLY_WAIT_CYCLES(WAIT)) i_dut (.clock, .rst_b,
		.dual_role_port, .role, .hard_reset, .swap_request, .req_cell_status,
		.req_maker_info, .req_sec_query, .req_arg, .mgr_data_valid, .mgr_data,
		.mgr_fetch, .mgr_fetch_kind, .mgr_fetch_arg, .report_valid, .report, .busy,
		.swap_start, .to_default, .rx_valid, .rx_msg, .tx_done, .tx_valid, .tx_msg);
	pd_partner_model i_far (.clock, .rst_b, .tx_valid, .tx_msg, .tx_done, .rx_valid,
		.rx_msg, .answer, .inj_valid, .inj_msg);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// manager answers each fetch after a short, varying delay
	always @(posedge clock) begin
		mgr_data_valid <= 1'b0;
		if (mcnt == 1) begin
			mgr_data_valid <= 1'b1;
			mgr_data <= f_data(mgr_fetch_arg);
		end
		if (mcnt > 0)
			mcnt <= mcnt - 1;
		else if (mgr_fetch === 1'b1)
			mcnt <= 1 + int'(mgr_fetch_arg[1:0]);
	end

	// ------------------------------------------------------------
	// expectations and helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] f_data(input logic [31:0] a);
		return a ^ 32'h5a5a0f0f;
	endfunction

	function automatic pd_info_pkg::msg_kind_t f_reply(input pd_info_pkg::msg_kind_t k);
		case (k)
			pd_info_pkg::msg_get_battery_caps: return pd_info_pkg::msg_battery_caps;
			pd_info_pkg::msg_get_cell_status:  return pd_info_pkg::msg_cell_status;
			pd_info_pkg::msg_get_maker_info:   return pd_info_pkg::msg_maker_info;
			default:                           return pd_info_pkg::msg_sec_answer;
		endcase
	endfunction

	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_sig(input int which, input int bound);
		h = 1'b0;
		for (n = 0; n < bound; n++) begin
			#1;
			case (which)
				0: h = tx_valid;
				1: h = mgr_fetch;
				2: h = report_valid;
				3: h = !busy;
				4: h = swap_start;
				default: h = to_default;
			endcase
			if (h === 1'b1)
				break;
			@(posedge clock);
		end
	endtask

	task automatic need(input int which, input string what);
		wait_sig(which, 60);
		if (h !== 1'b1) begin
			n_fail++;
			$display("MISMATCH %s expected 1 seen 0", what);
			finish_test();
		end
	endtask

	task automatic finish_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// partner-initiated message, then either served or ignored
	task automatic serve(input pd_info_pkg::msg_kind_t k, input logic take);
		logic [31:0] a;
		a = $random(seed);
		@(posedge clock);
		inj_valid <= 1'b1;
		inj_msg <= '{k, a};
		@(posedge clock);
		inj_valid <= 1'b0;
		if (k == pd_info_pkg::msg_sec_answer || !take) begin
			wait_sig(k == pd_info_pkg::msg_sec_answer ? 2 : 1, take ? 60 : 8);
			chk("taken", {35'h0, take}, {35'h0, h});
			if (take)
				chk("sec answer report", {pd_info_pkg::out_sec_answer, a}, report);
		end else begin
			need(1, "fetch");
			chk("fetch kind", f_reply(k), mgr_fetch_kind);
			chk("fetch arg", a, mgr_fetch_arg);
			need(0, "reply");
			chk("reply msg", {f_reply(k), f_data(a)}, tx_msg);
		end
		need(3, "back idle");
	endtask

	// manager request: 0 cell status, 1 maker info, 2 security query
	task automatic ask(input int which, input logic ans);
		logic [31:0]           a;
		pd_info_pkg::outcome_t exp;
		a = $random(seed);
		@(posedge clock);
		answer <= ans;
		req_arg <= a;
		case (which)
			0: req_cell_status <= 1'b1;
			1: req_maker_info <= 1'b1;
			default: req_sec_query <= 1'b1;
		endcase
		@(posedge clock);
		{req_cell_status, req_maker_info, req_sec_query} <= 3'h0;
		need(0, "request sent");
		exp.kind = which == 0 ? (ans ? pd_info_pkg::out_status_ok : pd_info_pkg::out_status_timeout)
			: (ans ? pd_info_pkg::out_maker_ok : pd_info_pkg::out_maker_timeout);
		exp.payload = ~a;
		chk("request msg", {which == 0 ? pd_info_pkg::msg_get_cell_status : which == 1 ?
			pd_info_pkg::msg_get_maker_info : pd_info_pkg::msg_sec_query, a}, tx_msg);
		if (which == 2) begin
			need(3, "query done");
			wait_sig(2, 4);
			chk("no report", 36'h0, {35'h0, h});
			return;
		end
		wait_sig(2, 60);
		chk("report seen", 36'h1, {35'h0, h});
		chk("report kind", exp.kind, report.kind);
		if (ans)
			chk("report data", exp.payload, report.payload);
		else
			chk("timer long enough", 36'h1, {35'h0, n >= WAIT - 2});
		need(3, "back idle");
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 91797;
		{rst_b, dual_role_port, hard_reset, swap_request, answer, inj_valid} = 6'h0;
		{req_cell_status, req_maker_info, req_sec_query} = 3'h0;
		{req_arg, inj_msg} = '0;
		role = pd_info_pkg::role_source;
		kinds = '{pd_info_pkg::msg_get_battery_caps, pd_info_pkg::msg_get_cell_status,
			pd_info_pkg::msg_get_maker_info, pd_info_pkg::msg_sec_query,
			pd_info_pkg::msg_sec_answer};
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		for (int r = 0; r < 3; r++) begin
			@(posedge clock);
			role <= pd_info_pkg::idle_role_t'(r);
			for (int i = 0; i < 5; i++)
				serve(kinds[i], r != 2 || i == 2 || i == 3);
			for (int i = 0; i < 5 && r < 2; i++)
				ask(i / 2, i % 2 == 0);
			$display("test role %0d done", r);
		end
		// hard reset in mid-request, then swap and reset with and without dual role
		// the role loop leaves cable idle, where a manager request is refused
		@(posedge clock);
		dual_role_port <= 1'b1;
		role <= pd_info_pkg::role_sink;
		answer <= 1'b0;
		req_cell_status <= 1'b1;
		@(posedge clock);
		req_cell_status <= 1'b0;
		need(0, "request sent");
		for (int d = 1; d >= 0; d--) begin
			@(posedge clock);
			dual_role_port <= d[0];
			hard_reset <= 1'b1;
			@(posedge clock);
			hard_reset <= 1'b0;
			wait_sig(5, 8);
			chk("to default", d, {35'h0, h});
			need(3, "idle after reset");
			@(posedge clock);
			swap_request <= 1'b1;
			@(posedge clock);
			swap_request <= 1'b0;
			wait_sig(4, 8);
			chk("swap start", d, {35'h0, h});
			need(3, "idle after swap");
		end
		$display("test role swap and reset done");
		finish_test();
	end
endmodule
`default_nettype wire
